/* File: expo_status_pkg.sv */
// Constants shared by the exposure status bank, its configuration port and thermometer.
// Assumes a 9-bit register address and 16-bit register words on the configuration port.
package expo_status_pkg;

    // Register address and data widths.
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    // Auto-exposure status group offsets.
    localparam logic [8:0] OFS_PIXEL_TALLY    = 9'h0b8;
    localparam logic [8:0] OFS_AVERAGE_LEVEL  = 9'h0ba;
    localparam logic [8:0] OFS_COMPUTED_EXPO  = 9'h0bb;
    localparam logic [8:0] OFS_COMPUTED_GAINS = 9'h0bc;

    // Applied (sequencer) status group offsets.
    localparam logic [8:0] OFS_TIME_STEP_MULT = 9'h0f2;
    localparam logic [8:0] OFS_CLEAR_LENGTH   = 9'h0f3;
    localparam logic [8:0] OFS_APPLIED_EXPO   = 9'h0f4;
    localparam logic [8:0] OFS_SECOND_SLOPE   = 9'h0f5;
    localparam logic [8:0] OFS_THIRD_SLOPE    = 9'h0f6;
    localparam logic [8:0] OFS_APPLIED_GAINS  = 9'h0f7;
    localparam logic [8:0] OFS_FINE_AND_SLOPE = 9'h0f8;

    // Thermometer count and control word.
    localparam logic [8:0] OFS_TEMP_COUNT     = 9'h1e0;
    localparam logic [8:0] OFS_TEMP_CTRL      = 9'h1e1;

    // Field positions inside the packed status words.
    localparam int AVG_W         = 10;
    localparam int CGAIN1_LSB    = 0;
    localparam int CGAIN2_LSB    = 2;
    localparam int CDGAIN_LSB    = 4;
    localparam int AGAIN1_LSB    = 0;
    localparam int AGAIN2_LSB    = 5;
    localparam int FINE_GAIN_LSB = 0;
    localparam int DUAL_BIT      = 12;
    localparam int TRIPLE_BIT    = 13;
    localparam int TEMP_EN_BIT   = 0;

    // Reset values.
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam logic [7:0]  TEMP_RESET    = 8'h00;
    localparam logic        TEMP_EN_RESET = 1'b0;

    // Configuration port frame: 9 address bits, 1 write bit, 16 data bits.
    localparam logic [4:0] SPI_ADDR_LAST  = 5'h08;
    localparam logic [4:0] SPI_CMD_LAST   = 5'h09;
    localparam logic [4:0] SPI_DATA_FIRST = 5'h0a;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h19;

    // Evaluation phase of the auto-exposure loop.
    typedef enum logic {AE_EVALUATE, AE_SETTLE} ae_phase_t;

endpackage : expo_status_pkg

/* File: spi_reg_if.sv */
// Carrier between the configuration port and the register bank.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
interface spi_reg_if;
    logic [8:0]  addr;
    logic        wr_stb;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport initiator (output addr, output wr_stb, output wdata, input rdata);
    modport target    (input addr, input wr_stb, input wdata, output rdata);
endinterface : spi_reg_if

/* File: die_thermometer.sv */
// Digital side of the on-die temperature sensor: captures the 8-bit count.
// Assumes the raw count arrives from the analog digitiser, asynchronous to clk_sys_i.
`timescale 1ns/100ps
module die_thermometer
    import expo_status_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       enable_i,
    input  wire logic [7:0] sense_i,
    output logic      [7:0] count_o
);
    logic [7:0] sense_s1_r;
    logic [7:0] sense_s2_r;
    logic [7:0] sense_s3_r;

    // Two-stage synchroniser followed by a compare stage for a stable word.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sense_s1_r <= TEMP_RESET;
            sense_s2_r <= TEMP_RESET;
            sense_s3_r <= TEMP_RESET;
        end else begin
            sense_s1_r <= sense_i;
            sense_s2_r <= sense_s1_r;
            sense_s3_r <= sense_s2_r;
        end
    end

    // The count is held at zero while disabled and only takes a word seen twice alike.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || !enable_i) begin
            count_o <= TEMP_RESET;
        end else if (sense_s2_r == sense_s3_r) begin
            count_o <= sense_s2_r;
        end
    end
endmodule : die_thermometer

/* File: spi_config_port.sv */
// Serial configuration port slave: address, write bit, then a 16-bit data word.
// Assumes SCK idles low, bits MSB first, sampled on the rising edge, and each
// SCK half period spans at least four clk_sys_i periods.
`timescale 1ns/100ps
module spi_config_port
    import expo_status_pkg::*;
(
    input  wire logic  clk_sys_i,
    input  wire logic  resetn_i,
    input  wire logic  spi_sck_i,
    input  wire logic  spi_cs_n_i,
    input  wire logic  spi_mosi_i,
    output logic       spi_miso_o,
    spi_reg_if.initiator bus
);
    logic [2:0]  sck_r;
    logic [1:0]  cs_n_r;
    logic [1:0]  mosi_r;
    logic        rise_w;
    logic        fall_w;
    logic [4:0]  bit_cnt_r;
    logic [15:0] shift_in_r;
    logic [15:0] shift_out_r;
    logic        is_wr_r;

    // Pins pass two flip-flops; the third SCK stage only feeds edge detection.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sck_r  <= 3'h0;
            cs_n_r <= 2'h3;
            mosi_r <= 2'h0;
        end else begin
            sck_r  <= {sck_r[1:0], spi_sck_i};
            cs_n_r <= {cs_n_r[0], spi_cs_n_i};
            mosi_r <= {mosi_r[0], spi_mosi_i};
        end
    end

    assign rise_w = sck_r[1] & ~sck_r[2];
    assign fall_w = ~sck_r[1] & sck_r[2];

    // Receive shifter, bit counter, address and write flag.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || cs_n_r[1]) begin
            bit_cnt_r  <= 5'h00;
            shift_in_r <= WORD_RESET;
            is_wr_r    <= 1'b0;
            bus.wr_stb <= 1'b0;
            if (!resetn_i) begin
                bus.addr  <= 9'h000;
                bus.wdata <= WORD_RESET;
            end
        end else begin
            bus.wr_stb <= 1'b0;
            if (rise_w) begin
                shift_in_r <= {shift_in_r[14:0], mosi_r[1]};
                bit_cnt_r  <= bit_cnt_r + 5'h01;
                if (bit_cnt_r == SPI_ADDR_LAST) begin
                    bus.addr <= {shift_in_r[7:0], mosi_r[1]};
                end
                if (bit_cnt_r == SPI_CMD_LAST) begin
                    is_wr_r <= mosi_r[1];
                end
                if (bit_cnt_r == SPI_FRAME_LAST && is_wr_r) begin
                    bus.wdata  <= {shift_in_r[14:0], mosi_r[1]};
                    bus.wr_stb <= 1'b1;
                end
            end
        end
    end

    // Transmit shifter: read data leaves MSB first on falling SCK edges.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || cs_n_r[1]) begin
            shift_out_r <= WORD_RESET;
            spi_miso_o  <= 1'b0;
        end else if (fall_w && bit_cnt_r == SPI_DATA_FIRST) begin
            shift_out_r <= {bus.rdata[14:0], 1'b0};
            spi_miso_o  <= bus.rdata[15];
        end else if (fall_w && bit_cnt_r > SPI_DATA_FIRST) begin
            shift_out_r <= {shift_out_r[14:0], 1'b0};
            spi_miso_o  <= shift_out_r[15];
        end
    end
endmodule : spi_config_port

/* File: exposure_status_bank.sv */
// Exposure status bank with die thermometer, read by the host over the serial port.
// Assumes the loop and sequencer inputs share clk_sys_i; serial pins are asynchronous.
//
// Summary of operation
// - The loop-computed group refreshes when the loop issues new parameters to the sequencer.
// - The applied group refreshes only when its parameters take effect on the readout image.
// - A 16-bit read-only word reports how many pixels entered the statistics.
// - A 10-bit read-only field reports the average illumination of the current frame.
// - Computed exposure and both analog gain codes load into their fields at an evaluated frame end.
// - Computed digital gain sits in bits 15 to 4 as an unsigned 5.7 value.
// - Time-step multiplier, array clear length and applied exposure are 16-bit words.
// - Applied second- and third-slope exposures are 16-bit words from user setup only.
// - Applied first-stage gain sits in bits 4 to 0 and second-stage gain in bits 12 to 5.
// - Applied digital gain is a 12-bit unsigned field with seven fraction bits.
// - Two single-bit flags show whether two- or three-slope integration is active.
// - The die temperature is an 8-bit count from 0 to 255 rising with temperature.
// - The temperature count is readable over the serial configuration port.
// - The thermometer runs while its enable bit is high and is held in reset when low.
// - The loop evaluates and updates its parameters only on every second frame.
`timescale 1ns/100ps
module exposure_status_bank
    import expo_status_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // Serial configuration port.
    input  wire logic        spi_sck_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    // Auto-exposure loop results, offered with a frame-end pulse.
    input  wire logic        ae_frame_end_i,
    input  wire logic [15:0] ae_pixel_tally_i,
    input  wire logic [9:0]  ae_average_level_i,
    input  wire logic [15:0] ae_exposure_i,
    input  wire logic [1:0]  ae_gain1_i,
    input  wire logic [1:0]  ae_gain2_i,
    input  wire logic [11:0] ae_digital_gain_i,
    // Sequencer values, offered with a pulse when they take effect on the image.
    input  wire logic        seq_apply_i,
    input  wire logic [15:0] seq_time_step_mult_i,
    input  wire logic [15:0] seq_clear_length_i,
    input  wire logic [15:0] seq_exposure_i,
    input  wire logic [15:0] second_slope_exposure_i,
    input  wire logic [15:0] third_slope_exposure_i,
    input  wire logic [4:0]  seq_gain1_i,
    input  wire logic [7:0]  seq_gain2_i,
    input  wire logic [11:0] applied_fine_gain_i,
    input  wire logic        dual_slope_i,
    input  wire logic        triple_slope_i,
    // Raw count from the temperature digitiser.
    input  wire logic [7:0]  temp_sense_i,
    output logic             thermometer_enable_o
);
    import expo_status_pkg::*;

    spi_reg_if reg_bus ();

    ae_phase_t   ae_phase_r;
    logic        ae_load_w;
    logic [15:0] ae_pixel_tally_r;
    logic [9:0]  ae_average_level_r;
    logic [15:0] ae_exposure_r;
    logic [1:0]  ae_gain1_r;
    logic [1:0]  ae_gain2_r;
    logic [11:0] ae_digital_gain_r;
    logic [15:0] time_step_mult_r;
    logic [15:0] clear_length_r;
    logic [15:0] applied_exposure_r;
    logic [15:0] second_slope_exposure_r;
    logic [15:0] third_slope_exposure_r;
    logic [4:0]  applied_gain1_r;
    logic [7:0]  applied_gain2_r;
    logic [11:0] applied_fine_gain_r;
    logic        dual_slope_r;
    logic        triple_slope_r;
    logic        temp_enable_r;
    logic [7:0]  temp_count_w;
    logic [15:0] rdata_nxt;

    // Serial slave that turns frames into register reads and writes.
    spi_config_port port_u (
        .clk_sys_i  (clk_sys_i),
        .resetn_i   (resetn_i),
        .spi_sck_i  (spi_sck_i),
        .spi_cs_n_i (spi_cs_n_i),
        .spi_mosi_i (spi_mosi_i),
        .spi_miso_o (spi_miso_o),
        .bus        (reg_bus.initiator)
    );

    // Thermometer capture, gated by the enable bit.
    die_thermometer thermo_u (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .enable_i  (temp_enable_r),
        .sense_i   (temp_sense_i),
        .count_o   (temp_count_w)
    );

    // Alternate frames: an exposure change needs a frame to settle before re-evaluation.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ae_phase_r <= AE_EVALUATE;
        end else if (ae_frame_end_i) begin
            ae_phase_r <= (ae_phase_r == AE_EVALUATE) ? AE_SETTLE : AE_EVALUATE;
        end
    end

    assign ae_load_w = ae_frame_end_i && (ae_phase_r == AE_EVALUATE);

    // Loop-computed group, all fields captured on the same edge.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ae_pixel_tally_r   <= WORD_RESET;
            ae_average_level_r <= WORD_RESET[9:0];
            ae_exposure_r      <= WORD_RESET;
            ae_gain1_r         <= WORD_RESET[1:0];
            ae_gain2_r         <= WORD_RESET[1:0];
            ae_digital_gain_r  <= WORD_RESET[11:0];
        end else if (ae_load_w) begin
            ae_pixel_tally_r   <= ae_pixel_tally_i;
            ae_average_level_r <= ae_average_level_i;
            ae_exposure_r      <= ae_exposure_i;
            ae_gain1_r         <= ae_gain1_i;
            ae_gain2_r         <= ae_gain2_i;
            ae_digital_gain_r  <= ae_digital_gain_i;
        end
    end

    // Applied group, captured only when the sequencer says the values are in effect.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            time_step_mult_r        <= WORD_RESET;
            clear_length_r          <= WORD_RESET;
            applied_exposure_r      <= WORD_RESET;
            second_slope_exposure_r <= WORD_RESET;
            third_slope_exposure_r  <= WORD_RESET;
            applied_gain1_r         <= WORD_RESET[4:0];
            applied_gain2_r         <= WORD_RESET[7:0];
            applied_fine_gain_r     <= WORD_RESET[11:0];
            dual_slope_r            <= 1'b0;
            triple_slope_r          <= 1'b0;
        end else if (seq_apply_i) begin
            time_step_mult_r        <= seq_time_step_mult_i;
            clear_length_r          <= seq_clear_length_i;
            applied_exposure_r      <= seq_exposure_i;
            second_slope_exposure_r <= second_slope_exposure_i;
            third_slope_exposure_r  <= third_slope_exposure_i;
            applied_gain1_r         <= seq_gain1_i;
            applied_gain2_r         <= seq_gain2_i;
            applied_fine_gain_r     <= applied_fine_gain_i;
            dual_slope_r            <= dual_slope_i;
            triple_slope_r          <= triple_slope_i;
        end
    end

    // The thermometer enable is the only writable bit; status words drop writes.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            temp_enable_r <= TEMP_EN_RESET;
        end else if (reg_bus.wr_stb && reg_bus.addr == OFS_TEMP_CTRL) begin
            temp_enable_r <= reg_bus.wdata[TEMP_EN_BIT];
        end
    end

    assign thermometer_enable_o = temp_enable_r;

    // Read decode; unmapped addresses and unused bits read as zero.
    always_comb begin
        rdata_nxt = WORD_RESET;
        case (reg_bus.addr)
            OFS_PIXEL_TALLY:    rdata_nxt = ae_pixel_tally_r;
            OFS_AVERAGE_LEVEL:  rdata_nxt[AVG_W-1:0] = ae_average_level_r;
            OFS_COMPUTED_EXPO:  rdata_nxt = ae_exposure_r;
            OFS_COMPUTED_GAINS: begin
                rdata_nxt[CGAIN1_LSB +: 2]  = ae_gain1_r;
                rdata_nxt[CGAIN2_LSB +: 2]  = ae_gain2_r;
                rdata_nxt[CDGAIN_LSB +: 12] = ae_digital_gain_r;
            end
            OFS_TIME_STEP_MULT: rdata_nxt = time_step_mult_r;
            OFS_CLEAR_LENGTH:   rdata_nxt = clear_length_r;
            OFS_APPLIED_EXPO:   rdata_nxt = applied_exposure_r;
            OFS_SECOND_SLOPE:   rdata_nxt = second_slope_exposure_r;
            OFS_THIRD_SLOPE:    rdata_nxt = third_slope_exposure_r;
            OFS_APPLIED_GAINS: begin
                rdata_nxt[AGAIN1_LSB +: 5] = applied_gain1_r;
                rdata_nxt[AGAIN2_LSB +: 8] = applied_gain2_r;
            end
            OFS_FINE_AND_SLOPE: begin
                rdata_nxt[FINE_GAIN_LSB +: 12] = applied_fine_gain_r;
                rdata_nxt[DUAL_BIT]            = dual_slope_r;
                rdata_nxt[TRIPLE_BIT]          = triple_slope_r;
            end
            OFS_TEMP_COUNT:     rdata_nxt[7:0] = temp_count_w;
            OFS_TEMP_CTRL:      rdata_nxt[TEMP_EN_BIT] = temp_enable_r;
            default:            rdata_nxt = WORD_RESET;
        endcase
    end

    // Registered read data; a read changes nothing in the bank.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reg_bus.rdata <= WORD_RESET;
        end else begin
            reg_bus.rdata <= rdata_nxt;
        end
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_ae_evaluate;
        ae_frame_end_i && ae_phase_r == AE_EVALUATE;
    endsequence

    sequence s_ae_settle;
        ae_frame_end_i && ae_phase_r == AE_SETTLE;
    endsequence

    sequence s_seq_apply;
        seq_apply_i;
    endsequence

    AST_AE_LOAD: assert property (
        s_ae_evaluate |=> ae_exposure_r == $past(ae_exposure_i)
            && ae_gain1_r == $past(ae_gain1_i) && ae_gain2_r == $past(ae_gain2_i))
        else $error("Computed exposure not loaded at evaluated frame end.");

    AST_AE_SKIP_SECOND: assert property (
        s_ae_settle |=> $stable(ae_exposure_r) && $stable(ae_digital_gain_r))
        else $error("Loop status changed on a settle frame.");

    AST_AE_ALTERNATE: assert property (
        s_ae_evaluate |=> ae_phase_r == AE_SETTLE)
        else $error("Loop evaluation phase did not alternate.");

    AST_SEQ_HOLD: assert property (
        !seq_apply_i |=> $stable(applied_exposure_r) && $stable(dual_slope_r))
        else $error("Applied status changed without an apply pulse.");

    AST_SEQ_LOAD: assert property (
        seq_apply_i |=> second_slope_exposure_r == $past(second_slope_exposure_i)
            && triple_slope_r == $past(triple_slope_i))
        else $error("Applied slope values not captured on apply.");

    AST_GROUP_ATOMIC: assert property (
        $changed(ae_pixel_tally_r) |-> $changed(ae_phase_r))
        else $error("Loop group word changed outside a load.");

    AST_WRITE_IGNORED: assert property (
        reg_bus.wr_stb && reg_bus.addr == OFS_APPLIED_EXPO && !seq_apply_i
            |=> $stable(applied_exposure_r))
        else $error("Host write altered a status word.");

    AST_TEMP_DISABLED: assert property (
        (!temp_enable_r)[*2] |-> temp_count_w == TEMP_RESET)
        else $error("Thermometer count not held while disabled.");

    AST_TEMP_READ: assert property (
        reg_bus.addr == OFS_TEMP_COUNT && $stable(reg_bus.addr)
            |=> reg_bus.rdata == {8'h00, $past(temp_count_w)})
        else $error("Temperature count read back wrong.");

    AST_GAIN_FIELD: assert property (
        reg_bus.addr == OFS_COMPUTED_GAINS
            |=> reg_bus.rdata[15:4] == $past(ae_digital_gain_r))
        else $error("Digital gain not in the upper twelve bits.");

    // Field capture, hold and read-back checks.

    AST_AE_STATS_LOAD: assert property (
        s_ae_evaluate |=> ae_pixel_tally_r == $past(ae_pixel_tally_i)
            && ae_average_level_r == $past(ae_average_level_i))
        else $error("Loop statistics not loaded.");

    AST_AE_DGAIN_LOAD: assert property (
        s_ae_evaluate |=> ae_digital_gain_r == $past(ae_digital_gain_i))
        else $error("Computed digital gain not loaded.");

    AST_AE_IDLE_HOLD: assert property (
        !ae_frame_end_i |=> $stable(ae_exposure_r) && $stable(ae_gain1_r))
        else $error("Computed exposure changed without a frame end.");

    AST_SEQ_WORDS: assert property (
        s_seq_apply |=> time_step_mult_r == $past(seq_time_step_mult_i)
            && clear_length_r == $past(seq_clear_length_i))
        else $error("Applied words not captured on apply.");

    AST_SEQ_GAINS: assert property (
        s_seq_apply |=> applied_gain1_r == $past(seq_gain1_i)
            && applied_gain2_r == $past(seq_gain2_i))
        else $error("Applied gains not captured on apply.");

    AST_FLAG_READ: assert property (
        reg_bus.addr == OFS_FINE_AND_SLOPE |=> reg_bus.rdata[TRIPLE_BIT] == $past(triple_slope_r)
            && reg_bus.rdata[DUAL_BIT] == $past(dual_slope_r))
        else $error("Slope flags read back wrong.");

endmodule : exposure_status_bank

/* File: spi_host_model.sv */
// Behavioural host on the serial configuration port: address, write bit, data word.
// Assumes the bench calls xfer and that one SCK half period spans five system clocks.
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic clk_sys_i,
    input  wire logic spi_miso_i,
    output logic      spi_sck_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o
);
    // Idle lines: the serial clock stands still and the device is deselected.
    initial begin
        spi_sck_o  = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    // Waits n system clocks and steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #10;
    endtask : tick

    // One whole frame, MSB first; read bits are taken on rising SCK edges 11 to 26.
    task automatic xfer(input logic [8:0] addr, input logic wr, input logic [15:0] wdata,
                        output logic [15:0] rdata);
        logic [25:0] frame;
        frame = {addr, wr, wdata};
        rdata = 16'h0000;
        tick(1);
        spi_cs_n_o = 1'b0;
        for (int i = 25; i >= 0; i--) begin
            spi_mosi_o = frame[i];
            tick(5);
            spi_sck_o = 1'b1;
            if (i < 16) rdata[i] = spi_miso_i;
            tick(5);
            spi_sck_o = 1'b0;
        end
        tick(5);
        spi_cs_n_o = 1'b1;
        // A released data line shows the inverse of its last bit, never a stale value.
        spi_mosi_o = ~spi_mosi_o;
        tick(5);
    endtask : xfer
endmodule : spi_host_model

/* File: test_exposure_status_and_thermometer.sv */
// Self-checking bench for the exposure status bank and its thermometer.
// Assumes the host model drives the serial port; the bench drives loop and sequencer inputs.
`timescale 1ns/100ps
module test_exposure_status_and_thermometer;
    import expo_status_pkg::*;

    typedef struct packed {
        logic [15:0] tsm, clr, expo, s2, s3;
        logic [4:0]  g1;
        logic [7:0]  g2;
        logic [11:0] fg;
        logic        ds, ts;
    } seq_row_t;

    logic        clk_sys_i    = 1'b0;
    logic        resetn_i     = 1'b0;
    logic        ae_frame_end = 1'b0;
    logic        seq_apply    = 1'b0;
    logic [15:0] ae_tally     = 16'h0000;
    logic [15:0] ae_expo      = 16'h0000;
    logic [9:0]  ae_avg       = 10'h000;
    logic [1:0]  ae_g1        = 2'h0;
    logic [1:0]  ae_g2        = 2'h0;
    logic [11:0] ae_dg        = 12'h000;
    logic [7:0]  temp_sense   = 8'h00;
    seq_row_t    seq          = '0;
    logic        spi_sck, spi_cs_n, spi_mosi, spi_miso, thermo_en;
    logic [15:0] rd;
    int          failures     = 0;
    int          comparisons  = 0;
    seq_row_t    rows [3]     = '{
        '{16'hffff, 16'h0001, 16'h8000, 16'h1234, 16'hfedc, 5'h1f, 8'h00, 12'hfff, 1'b1, 1'b0},
        '{16'h0000, 16'hfffe, 16'h7fff, 16'hedcb, 16'h0123, 5'h00, 8'hff, 12'h000, 1'b0, 1'b1},
        '{16'ha5a5, 16'h5a5a, 16'h0f0f, 16'hf0f0, 16'h3c3c, 5'h15, 8'haa, 12'h555, 1'b1, 1'b1}};

    // System clock, 100 ns period.
    always #50 clk_sys_i = ~clk_sys_i;

    spi_host_model u_host (.clk_sys_i(clk_sys_i), .spi_miso_i(spi_miso), .spi_sck_o(spi_sck),
                           .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi));

    exposure_status_bank u_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi_sck_i(spi_sck),
        .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
        .ae_frame_end_i(ae_frame_end), .ae_pixel_tally_i(ae_tally),
        .ae_average_level_i(ae_avg), .ae_exposure_i(ae_expo), .ae_gain1_i(ae_g1),
        .ae_gain2_i(ae_g2), .ae_digital_gain_i(ae_dg), .seq_apply_i(seq_apply),
        .seq_time_step_mult_i(seq.tsm), .seq_clear_length_i(seq.clr),
        .seq_exposure_i(seq.expo), .second_slope_exposure_i(seq.s2),
        .third_slope_exposure_i(seq.s3), .seq_gain1_i(seq.g1), .seq_gain2_i(seq.g2),
        .applied_fine_gain_i(seq.fg), .dual_slope_i(seq.ds), .triple_slope_i(seq.ts),
        .temp_sense_i(temp_sense), .thermometer_enable_o(thermo_en));

    // Waits n clocks and steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #10;
    endtask : tick

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Reads one register over the serial port and compares it.
    task automatic rd_chk(input logic [8:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        u_host.xfer(addr, 1'b0, 16'h0000, d);
        check($sformatf("register %h", addr), d, exp);
    endtask : rd_chk

    // Writes one register over the serial port.
    task automatic wr(input logic [8:0] addr, input logic [15:0] data);
        u_host.xfer(addr, 1'b1, data, rd);
    endtask : wr

    // Offers loop results derived from q with a one-cycle frame-end pulse.
    task automatic ae_step(input logic [3:0] q);
        ae_tally = {12'hfff, q};
        ae_avg = {6'h2a, q};
        ae_expo = {q, 12'h800};
        ae_g1 = q[1:0];
        ae_g2 = ~q[1:0];
        ae_dg = {q, 8'h81};
        ae_frame_end = 1'b1;
        tick(1);
        ae_frame_end = 1'b0;
    endtask : ae_step

    // Expects the loop group to hold the values derived from q.
    task automatic ae_expect(input logic [3:0] q);
        rd_chk(OFS_PIXEL_TALLY, {12'hfff, q});
        rd_chk(OFS_AVERAGE_LEVEL, {6'h00, 6'h2a, q});
        rd_chk(OFS_COMPUTED_EXPO, {q, 12'h800});
        rd_chk(OFS_COMPUTED_GAINS, {q, 8'h81, ~q[1:0], q[1:0]});
    endtask : ae_expect

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // Watchdog well beyond the expected 1.5 ms of traffic.
    initial begin
        #5_000_000;
        failures++;
        $display("watchdog expired");
        end_sim();
    end

    // Main sequence.
    initial begin
        tick(8);
        resetn_i = 1'b1;
        tick(5);
        // Applied group rows; inputs move away right after each pulse.
        foreach (rows[k]) begin
            seq = rows[k];
            seq_apply = 1'b1;
            tick(1);
            seq_apply = 1'b0;
            seq = ~rows[k];
            rd_chk(OFS_TIME_STEP_MULT, rows[k].tsm);
            rd_chk(OFS_CLEAR_LENGTH, rows[k].clr);
            rd_chk(OFS_APPLIED_EXPO, rows[k].expo);
            rd_chk(OFS_SECOND_SLOPE, rows[k].s2);
            rd_chk(OFS_THIRD_SLOPE, rows[k].s3);
            rd_chk(OFS_APPLIED_GAINS, {3'b000, rows[k].g2, rows[k].g1});
            rd_chk(OFS_FINE_AND_SLOPE, {2'b00, rows[k].ts, rows[k].ds, rows[k].fg});
        end
        $display("test applied rows done");
        // Loop group: pulse 1 evaluated, pulse 2 in the settle frame, pulse 3 evaluated.
        for (int p = 1; p <= 3; p++) begin
            ae_step(4'(p));
            ae_expect((p == 2) ? 4'h1 : 4'(p));
        end
        $display("test loop group done");
        // Writes to status words and an unmapped read.
        wr(OFS_APPLIED_EXPO, 16'h1111);
        wr(OFS_COMPUTED_EXPO, 16'h2222);
        rd_chk(OFS_APPLIED_EXPO, rows[2].expo);
        rd_chk(OFS_COMPUTED_EXPO, 16'h3800);
        rd_chk(9'h100, 16'h0000);
        $display("test read only done");
        // Thermometer enabled at full scale, then a mid value, then disabled.
        temp_sense = 8'hff;
        wr(OFS_TEMP_CTRL, 16'h0001);
        check("thermometer enable", {15'h0000, thermo_en}, 16'h0001);
        rd_chk(OFS_TEMP_COUNT, 16'h00ff);
        temp_sense = 8'h5c;
        tick(8);
        rd_chk(OFS_TEMP_COUNT, 16'h005c);
        wr(OFS_TEMP_CTRL, 16'h0000);
        rd_chk(OFS_TEMP_COUNT, 16'h0000);
        $display("test thermometer done");
        // Mid-run reset clears everything and restarts the evaluate phase.
        wr(OFS_TEMP_CTRL, 16'h0001);
        resetn_i = 1'b0;
        tick(8);
        resetn_i = 1'b1;
        tick(5);
        check("thermometer enable", {15'h0000, thermo_en}, 16'h0000);
        rd_chk(OFS_APPLIED_EXPO, 16'h0000);
        rd_chk(OFS_TEMP_CTRL, 16'h0000);
        rd_chk(OFS_PIXEL_TALLY, WORD_RESET);
        rd_chk(OFS_AVERAGE_LEVEL, WORD_RESET);
        rd_chk(OFS_COMPUTED_EXPO, WORD_RESET);
        rd_chk(OFS_COMPUTED_GAINS, WORD_RESET);
        ae_step(4'h5);
        ae_expect(4'h5);
        $display("test reset done");
        end_sim();
    end
endmodule : test_exposure_status_and_thermometer
